// [include/csad_pkg.sv]
// Constants and types shared by the chip select area decoder.
// Assumes a 32-bit APB register port and a 24-bit external address bus.
package csad_pkg;

  // ==========================================================
  // Register indices (byte address is four times the index)
  // ==========================================================
  localparam logic [7:0] IDX_AREA0_BASE = 8'h3c;
  localparam logic [7:0] IDX_AREA0_MASK = 8'h3d;
  localparam logic [7:0] IDX_AREA1_BASE = 8'h3e;
  localparam logic [7:0] IDX_AREA1_MASK = 8'h3f;
  localparam logic [7:0] IDX_AREA2_BASE = 8'h5c;
  localparam logic [7:0] IDX_AREA2_MASK = 8'h5d;
  localparam logic [7:0] IDX_AREA3_BASE = 8'h5e;
  localparam logic [7:0] IDX_AREA3_MASK = 8'h5f;
  localparam logic [7:0] IDX_AREA0_CTRL = 8'h68;
  localparam logic [7:0] IDX_AREA1_CTRL = 8'h69;
  localparam logic [7:0] IDX_AREA2_CTRL = 8'h6a;
  localparam logic [7:0] IDX_AREA3_CTRL = 8'h6b;
  localparam logic [7:0] IDX_DEFAULT_CTRL = 8'h6c;
  localparam logic [7:0] IDX_STATUS = 8'h6d;

  // ==========================================================
  // Control register fields
  // ==========================================================
  localparam int CTRL_ENABLE = 4;
  localparam int CTRL_MODE = 3;
  localparam int CTRL_WIDTH = 2;
  localparam int CTRL_WAIT_HI = 1;
  localparam int CTRL_WAIT_LO = 0;
  localparam logic [7:0] CTRL_WMASK_01 = 8'h17;
  localparam logic [7:0] CTRL_WMASK_23 = 8'h1f;
  localparam logic [7:0] CTRL_WMASK_DEF = 8'h07;

  // ==========================================================
  // Reset values
  // ==========================================================
  localparam logic [7:0] BASE_RST = 8'hff;
  localparam logic [7:0] MASK_RST = 8'hff;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] CTRL2_RST = 8'h10;

  // ==========================================================
  // Wait codes, area codes, address limits
  // ==========================================================
  localparam logic [1:0] WAIT_TWO = 2'h0;
  localparam logic [1:0] WAIT_ONE = 2'h1;
  localparam logic [1:0] WAIT_EXT = 2'h2;
  localparam logic [1:0] WAIT_NONE = 2'h3;
  localparam logic [2:0] AREA_DEFAULT = 3'h4;
  localparam logic [23:0] FULL_SPACE_START = 24'h000080;

  // Bus cycle sequencer states
  typedef enum logic [2:0]
  {
    ST_IDLE = 3'h1,
    ST_SETUP = 3'h2,
    ST_BEAT = 3'h4
  } fsm_t;

endpackage

// [hdl/chip_select_area_decoder.sv]
// Chip select area decoder with wait control and dynamic bus sizing.
// Assumes an APB master for registers and a CPU side that issues one
// operand request at a time and waits for its done pulse.

module chip_select_area_decoder
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_srst,
  // APB register port
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // CPU operand request
  input wire logic i_cycle_start,
  input wire logic i_cycle_write,
  input wire logic [23:0] i_cycle_addr,
  input wire logic [2:0] i_cycle_size,
  input wire logic [31:0] i_cycle_wdata,
  output logic o_cycle_done,
  output logic o_cycle_busy,
  output logic [31:0] o_cycle_rdata,
  // External bus pins
  input wire logic i_bus_width_strap,
  input wire logic i_wait_n,
  input wire logic [7:0] i_data_lo,
  input wire logic [7:0] i_data_hi,
  output logic [7:0] o_data_lo,
  output logic [7:0] o_data_hi,
  output logic o_data_lo_oe,
  output logic o_data_hi_oe,
  output logic [23:0] o_addr,
  output logic o_rd_n,
  output logic o_wr_lo_n,
  output logic o_wr_hi_n,
  output logic o_area_sel_0_n,
  output logic o_area_sel_1_n,
  output logic o_area_sel_2_n,
  output logic o_area_sel_3_n
);

  // ==========================================================
  // State
  // ==========================================================
  typedef struct packed {
    csad_pkg::fsm_t fsm;            // Sequencer state
    logic [3:0][7:0] base;          // Start address per area
    logic [3:0][7:0] mask;          // Compare mask per area
    logic [4:0][7:0] ctrl;          // Area controls, [4] is default
    logic [23:0] addr;              // Address of current beat
    logic [2:0] left;               // Operand bytes still to move
    logic [1:0] idx;                // Operand byte of current beat
    logic write;                    // Request direction
    logic [31:0] wdata;             // Operand to write
    logic [31:0] rdata;             // Operand gathered on read
    logic [2:0] area;               // Area chosen for current beat
    logic [1:0] wmode;              // Wait code of current beat
    logic [1:0] wcnt;               // Fixed waits still to run
    logic [1:0] step;               // Bytes moved by current beat
    logic use_lo;                   // Low lane carries a byte
    logic use_hi;                   // High lane carries a byte
    logic cas;                      // Area 3 in column strobe form
    logic [3:0] sel_n;              // Select pins
    logic [7:0] dlo;                // Low lane drive value
    logic [7:0] dhi;                // High lane drive value
    logic oe_lo;
    logic oe_hi;
    logic rd_n;
    logic wr_lo_n;
    logic wr_hi_n;
    logic done;                     // One-cycle completion pulse
    logic busy;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } core_t;

  core_t s;
  core_t next_s;

  // ==========================================================
  // Decoding functions
  // ==========================================================
  // Ignore vector per area: bits above the mask range always compare,
  // start bits below A16 are zero, grouped mask bits fan out.
  function automatic logic [23:0] ignore_bits(input logic [1:0] area,
                                              input logic [7:0] m);
    case (area)
      2'h0: return {3'h0, m[7:2], {6{m[1]}}, m[0], 8'hff};
      2'h1:
        return {2'h0, m[7:3], m[2], {7{m[1]}}, m[0], 8'hff};
      default: return {1'b0, m, 15'h7fff};
    endcase
  endfunction

  // Masked compare of the address with the start register
  function automatic logic area_hit(input logic [1:0] area,
                                    input logic [7:0] base,
                                    input logic [7:0] m,
                                    input logic [23:0] a);
    logic [23:0] ign;
    ign = ignore_bits(area, m);
    // Start sits at A23..A16 on a 64-Kbyte grid
    return &(ign | ~(a ^ {base, 16'h0000}));
  endfunction

  // Area for an address; lowest enabled match wins, else default
  function automatic logic [2:0] pick_area(input core_t c,
                                           input logic [23:0] a);
    logic [3:0] hit;
    logic [2:0] pick;
    for (int i = 0; i < 4; i++)
    begin
      hit[i] = c.ctrl[i][csad_pkg::CTRL_ENABLE] &
               area_hit(2'(i), c.base[i], c.mask[i], a);
    end
    if (!c.ctrl[2][csad_pkg::CTRL_MODE])
    begin
      // Full space form ignores start and mask
      hit[2] = c.ctrl[2][csad_pkg::CTRL_ENABLE] &
               (a >= csad_pkg::FULL_SPACE_START);
    end
    pick = csad_pkg::AREA_DEFAULT;
    for (int i = 3; i >= 0; i--)
    begin
      if (hit[i])
      begin
        pick = 3'(i);
      end
    end
    return pick;
  endfunction

  // ==========================================================
  // Next state
  // ==========================================================
  // One process builds the whole next state; register access first,
  // then the external bus sequencer, reset last so it overrides all.
  always_comb
  begin
    logic [9:0] ridx;
    logic [7:0] ctl;
    logic [2:0] area;
    logic [1:0] idx1;
    logic wide;
    logic mapped;
    logic [31:0] rval;
    ridx = i_paddr[11:2];
    ctl = 8'h00;
    area = 3'h0;
    idx1 = s.idx + 2'h1;
    wide = 1'b0;
    mapped = (i_paddr[1:0] == 2'h0);
    rval = 32'h0000_0000;
    next_s = s;
    next_s.done = 1'b0;
    next_s.pready = 1'b0;

    // Register decode, shared by reads and writes
    case (ridx)
      {2'h0, csad_pkg::IDX_AREA0_BASE}: rval[7:0] = s.base[0];
      {2'h0, csad_pkg::IDX_AREA0_MASK}: rval[7:0] = s.mask[0];
      {2'h0, csad_pkg::IDX_AREA1_BASE}: rval[7:0] = s.base[1];
      {2'h0, csad_pkg::IDX_AREA1_MASK}: rval[7:0] = s.mask[1];
      {2'h0, csad_pkg::IDX_AREA2_BASE}: rval[7:0] = s.base[2];
      {2'h0, csad_pkg::IDX_AREA2_MASK}: rval[7:0] = s.mask[2];
      {2'h0, csad_pkg::IDX_AREA3_BASE}: rval[7:0] = s.base[3];
      {2'h0, csad_pkg::IDX_AREA3_MASK}: rval[7:0] = s.mask[3];
      {2'h0, csad_pkg::IDX_AREA0_CTRL}: rval[7:0] = s.ctrl[0];
      {2'h0, csad_pkg::IDX_AREA1_CTRL}: rval[7:0] = s.ctrl[1];
      {2'h0, csad_pkg::IDX_AREA2_CTRL}: rval[7:0] = s.ctrl[2];
      {2'h0, csad_pkg::IDX_AREA3_CTRL}: rval[7:0] = s.ctrl[3];
      {2'h0, csad_pkg::IDX_DEFAULT_CTRL}: rval[7:0] = s.ctrl[4];
      // Live sequencer state for software
      {2'h0, csad_pkg::IDX_STATUS}: rval[7:0] = {4'h0, s.busy, s.area};
      default: mapped = 1'b0;
    endcase

    // Setup cycle: answer is ready for the access phase that follows
    if (i_psel && !i_penable && !s.pready)
    begin
      next_s.pready = 1'b1;
      next_s.pslverr = ~mapped;
      next_s.prdata = mapped ? rval : 32'h0000_0000;
    end

    // Write lands only at the completing access edge
    if (i_psel && i_penable && s.pready && i_pwrite && mapped)
    begin
      case (ridx)
        {2'h0, csad_pkg::IDX_AREA0_BASE}: next_s.base[0] = i_pwdata[7:0];
        {2'h0, csad_pkg::IDX_AREA0_MASK}: next_s.mask[0] = i_pwdata[7:0];
        {2'h0, csad_pkg::IDX_AREA1_BASE}: next_s.base[1] = i_pwdata[7:0];
        {2'h0, csad_pkg::IDX_AREA1_MASK}: next_s.mask[1] = i_pwdata[7:0];
        {2'h0, csad_pkg::IDX_AREA2_BASE}: next_s.base[2] = i_pwdata[7:0];
        {2'h0, csad_pkg::IDX_AREA2_MASK}: next_s.mask[2] = i_pwdata[7:0];
        {2'h0, csad_pkg::IDX_AREA3_BASE}: next_s.base[3] = i_pwdata[7:0];
        {2'h0, csad_pkg::IDX_AREA3_MASK}: next_s.mask[3] = i_pwdata[7:0];
        {2'h0, csad_pkg::IDX_AREA0_CTRL}:
          next_s.ctrl[0] = i_pwdata[7:0] & csad_pkg::CTRL_WMASK_01;
        {2'h0, csad_pkg::IDX_AREA1_CTRL}:
          next_s.ctrl[1] = i_pwdata[7:0] & csad_pkg::CTRL_WMASK_01;
        {2'h0, csad_pkg::IDX_AREA2_CTRL}:
          next_s.ctrl[2] = i_pwdata[7:0] & csad_pkg::CTRL_WMASK_23;
        {2'h0, csad_pkg::IDX_AREA3_CTRL}:
          next_s.ctrl[3] = i_pwdata[7:0] & csad_pkg::CTRL_WMASK_23;
        {2'h0, csad_pkg::IDX_DEFAULT_CTRL}:
          next_s.ctrl[4] = i_pwdata[7:0] & csad_pkg::CTRL_WMASK_DEF;
        // Status is read only
        default: next_s.busy = s.busy;
      endcase
    end

    // External bus sequencer
    case (s.fsm)
      csad_pkg::ST_IDLE:
      begin
        // Requests while busy are not taken; the CPU waits for done
        if (i_cycle_start)
        begin
          next_s.addr = i_cycle_addr;
          next_s.idx = 2'h0;
          next_s.left = (i_cycle_size == 3'h0) ? 3'h1 : i_cycle_size;
          next_s.write = i_cycle_write;
          next_s.wdata = i_cycle_wdata;
          next_s.rdata = 32'h0000_0000;
          next_s.busy = 1'b1;
          next_s.fsm = csad_pkg::ST_SETUP;
        end
      end
      csad_pkg::ST_SETUP:
      begin
        // Each beat is decoded afresh, so a split operand may cross areas
        area = pick_area(s, s.addr);
        ctl = s.ctrl[area];
        // Strap in 8-bit mode overrides the width bit
        wide = ~i_bus_width_strap & ~ctl[csad_pkg::CTRL_WIDTH];
        next_s.use_lo = 1'b1;
        next_s.use_hi = 1'b0;
        next_s.step = 2'h1;
        if (wide && s.addr[0])
        begin
          // Odd byte rides the high lane alone
          next_s.use_lo = 1'b0;
          next_s.use_hi = 1'b1;
        end
        else if (wide && s.left >= 3'h2)
        begin
          next_s.use_hi = 1'b1;
          next_s.step = 2'h2;
        end
        next_s.wmode = ctl[csad_pkg::CTRL_WAIT_HI:csad_pkg::CTRL_WAIT_LO];
        case (next_s.wmode)
          csad_pkg::WAIT_TWO: next_s.wcnt = 2'h2;
          csad_pkg::WAIT_ONE: next_s.wcnt = 2'h1;
          csad_pkg::WAIT_EXT: next_s.wcnt = 2'h1;
          default: next_s.wcnt = 2'h0;
        endcase
        // Column strobe comes one cycle late, so it needs a wait slot
        next_s.cas = (area == 3'h3) & s.ctrl[3][csad_pkg::CTRL_MODE];
        if (next_s.cas && next_s.wcnt == 2'h0)
        begin
          next_s.wcnt = 2'h1;
        end
        next_s.area = area;
        next_s.sel_n = 4'hf;
        if (area != csad_pkg::AREA_DEFAULT && !next_s.cas)
        begin
          next_s.sel_n[area[1:0]] = 1'b0;
        end
        // Idle lanes float and keep their strobe high
        next_s.rd_n = s.write;
        next_s.oe_lo = s.write & next_s.use_lo;
        next_s.oe_hi = s.write & next_s.use_hi;
        next_s.wr_lo_n = ~next_s.oe_lo;
        next_s.wr_hi_n = ~next_s.oe_hi;
        next_s.dlo = s.wdata[{s.idx, 3'h0} +: 8];
        next_s.dhi = next_s.use_lo ? s.wdata[{idx1, 3'h0} +: 8] :
                                     s.wdata[{s.idx, 3'h0} +: 8];
        next_s.fsm = csad_pkg::ST_BEAT;
      end
      csad_pkg::ST_BEAT:
      begin
        if (s.cas)
        begin
          next_s.sel_n[3] = 1'b0;
        end
        if (s.wcnt != 2'h0)
        begin
          next_s.wcnt = s.wcnt - 2'h1;
        end
        else if (s.wmode == csad_pkg::WAIT_EXT && !i_wait_n)
        begin
          // Pin holds the beat open
          next_s.wcnt = 2'h0;
        end
        else
        begin
          // Gather read bytes into operand order
          if (s.use_lo && s.use_hi)
          begin
            next_s.rdata[{s.idx, 3'h0} +: 8] = i_data_lo;
            next_s.rdata[{idx1, 3'h0} +: 8] = i_data_hi;
          end
          else if (s.use_lo)
          begin
            next_s.rdata[{s.idx, 3'h0} +: 8] = i_data_lo;
          end
          else
          begin
            next_s.rdata[{s.idx, 3'h0} +: 8] = i_data_hi;
          end
          next_s.addr = s.addr + {22'h0, s.step};
          next_s.idx = s.idx + s.step;
          next_s.left = s.left - {1'b0, s.step};
          // Release everything for at least one cycle
          next_s.sel_n = 4'hf;
          next_s.rd_n = 1'b1;
          next_s.wr_lo_n = 1'b1;
          next_s.wr_hi_n = 1'b1;
          next_s.oe_lo = 1'b0;
          next_s.oe_hi = 1'b0;
          next_s.cas = 1'b0;
          if (s.left == {1'b0, s.step})
          begin
            next_s.done = 1'b1;
            next_s.busy = 1'b0;
            next_s.fsm = csad_pkg::ST_IDLE;
          end
          else
          begin
            next_s.fsm = csad_pkg::ST_SETUP;
          end
        end
      end
      default: next_s.fsm = csad_pkg::ST_IDLE;
    endcase

    // Synchronous reset
    if (i_srst)
    begin
      next_s = '0;
      next_s.fsm = csad_pkg::ST_IDLE;
      next_s.base = {4{csad_pkg::BASE_RST}};
      next_s.mask = {4{csad_pkg::MASK_RST}};
      next_s.ctrl = {csad_pkg::CTRL_RST, csad_pkg::CTRL_RST,
                     csad_pkg::CTRL2_RST, csad_pkg::CTRL_RST,
                     csad_pkg::CTRL_RST};
      next_s.sel_n = 4'hf;
      next_s.rd_n = 1'b1;
      next_s.wr_lo_n = 1'b1;
      next_s.wr_hi_n = 1'b1;
    end
  end

  // ==========================================================
  // State register and outputs
  // ==========================================================
  // Every output is a field of this one register
  always_ff @(posedge i_clock)
  begin
    s <= next_s;
  end

  assign o_prdata = s.prdata;
  assign o_pready = s.pready;
  assign o_pslverr = s.pslverr;
  assign o_cycle_done = s.done;
  assign o_cycle_busy = s.busy;
  assign o_cycle_rdata = s.rdata;
  assign o_data_lo = s.dlo;
  assign o_data_hi = s.dhi;
  assign o_data_lo_oe = s.oe_lo;
  assign o_data_hi_oe = s.oe_hi;
  assign o_addr = s.addr;
  assign o_rd_n = s.rd_n;
  assign o_wr_lo_n = s.wr_lo_n;
  assign o_wr_hi_n = s.wr_hi_n;
  assign o_area_sel_0_n = s.sel_n[0];
  assign o_area_sel_1_n = s.sel_n[1];
  assign o_area_sel_2_n = s.sel_n[2];
  assign o_area_sel_3_n = s.sel_n[3];

  // ==========================================================
  // Assertions
  // ==========================================================
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_srst);

  // First cycle of a beat
  sequence beat_begin;
    s.fsm == csad_pkg::ST_BEAT && $past(s.fsm) == csad_pkg::ST_SETUP;
  endsequence

  AST_AREA3_CAS_LATE: assert property (
    beat_begin and s.cas |-> o_area_sel_3_n ##1 !o_area_sel_3_n)
    else $error("column strobe not delayed by one cycle");
  AST_NARROW_STRAP: assert property (
    i_bus_width_strap && $stable(i_bus_width_strap) &&
    s.fsm == csad_pkg::ST_BEAT |-> !s.use_hi && !o_data_hi_oe)
    else $error("high lane used in strapped narrow mode");
  AST_IDLE_LANE_FLOATS: assert property (
    !o_wr_hi_n || !o_wr_lo_n |-> (o_wr_hi_n || o_data_hi_oe) &&
    (o_wr_lo_n || o_data_lo_oe))
    else $error("write strobe on an undriven lane");
  AST_DEFAULT_NO_SELECT: assert property (
    s.fsm == csad_pkg::ST_BEAT && s.area == csad_pkg::AREA_DEFAULT
    |-> s.sel_n == 4'hf)
    else $error("select asserted for default area");
  AST_FULL_SPACE: assert property (
    !o_area_sel_2_n && !s.ctrl[2][csad_pkg::CTRL_MODE]
    |-> o_addr >= csad_pkg::FULL_SPACE_START)
    else $error("area 2 selected below full space start");
  AST_MATCH_0: assert property (
    !o_area_sel_0_n |-> s.ctrl[0][csad_pkg::CTRL_ENABLE] &&
    area_hit(2'h0, s.base[0], s.mask[0], o_addr))
    else $error("area 0 selected without enabled match");
  AST_ONE_SELECT: assert property (
    $onehot0(~s.sel_n))
    else $error("more than one select asserted");
  AST_PRIORITY_1: assert property (
    !o_area_sel_1_n |-> !(s.ctrl[0][csad_pkg::CTRL_ENABLE] &&
    area_hit(2'h0, s.base[0], s.mask[0], o_addr)))
    else $error("area 1 selected over matching area 0");
  AST_RESET_VALUES: assert property (
    $past(i_srst) |-> s.base == {4{csad_pkg::BASE_RST}} &&
    s.mask == {4{csad_pkg::MASK_RST}} && s.ctrl[2] == csad_pkg::CTRL2_RST)
    else $error("register reset value wrong");
  AST_TWO_WAIT: assert property (
    beat_begin and s.wmode == csad_pkg::WAIT_TWO and !s.cas
    |-> (s.fsm == csad_pkg::ST_BEAT)[*3] ##1 s.fsm != csad_pkg::ST_BEAT)
    else $error("two wait beat not three cycles long");
  AST_SELECT_HELD: assert property (
    s.fsm == csad_pkg::ST_BEAT && s.area != csad_pkg::AREA_DEFAULT &&
    !s.cas |-> !s.sel_n[s.area[1:0]])
    else $error("select dropped inside a beat");
  AST_SELECT_GAP: assert property (
    s.fsm != csad_pkg::ST_BEAT |-> s.sel_n == 4'hf)
    else $error("select asserted between beats");

endmodule

// [bench/ext_mem.sv]
// External memory model behind the decoder's two data lanes.
// Assumes address and strobes come straight from decoder registers.
module ext_mem
(
  input wire logic i_clock,
  input wire logic i_slow,
  input wire logic [23:0] i_addr,
  input wire logic i_rd_n,
  input wire logic i_wr_lo_n,
  input wire logic i_wr_hi_n,
  input wire logic [7:0] i_lo,
  input wire logic [7:0] i_hi,
  input wire logic i_lo_oe,
  input wire logic i_hi_oe,
  output logic [7:0] o_lo,
  output logic [7:0] o_hi,
  output logic o_wait_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [logic [23:0]];
  logic t = 0;
  int n = 0;
  function automatic logic [7:0] rd(logic [23:0] a);
    return mem.exists(a) ? mem[a] : a[7:0] ^ a[15:8] ^ 8'h3c;
  endfunction
  // Idle lanes toggle so stale data never passes for valid
  always @*
  begin
    o_lo = i_rd_n ? {8{t}} : rd(i_addr);
    o_hi = i_rd_n ? {8{t}} : rd(i_addr | 24'h1);
  end
  // An undriven strobed lane stores unknowns, caught on read back
  always @(posedge i_clock)
  begin
    t <= ~t;
    n = (i_rd_n && i_wr_lo_n && i_wr_hi_n) ? 0 : n + 1;
    o_wait_n <= !(i_slow && n < 3);
    if (!i_wr_lo_n)
      mem[i_addr] = i_lo_oe ? i_lo : 8'hxx;
    if (!i_wr_hi_n)
      mem[i_addr | 24'h1] = i_hi_oe ? i_hi : 8'hxx;
  end
endmodule

// [bench/test_chip_select_area_decoder.sv]
// Self-checking bench for the chip select area decoder.
// Assumes ext_mem on the pins and APB reaching the registers.
module test_chip_select_area_decoder;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [31:0] d, m; int lat; logic [3:0] sel;} exp_t;
  logic i_clock = 0, i_srst = 1, i_psel = 0, i_penable = 0, i_pwrite = 0;
  logic [11:0] i_paddr = 0;
  logic [31:0] i_pwdata = 0, o_prdata, i_cycle_wdata = 0, o_cycle_rdata;
  logic i_cycle_start = 0, i_cycle_write = 0, i_bus_width_strap = 0;
  logic [23:0] i_cycle_addr = 0, o_addr;
  logic [2:0] i_cycle_size = 1;
  logic [7:0] i_data_lo, i_data_hi, o_data_lo, o_data_hi, sh [logic [23:0]];
  logic o_pready, o_pslverr, o_cycle_done, o_cycle_busy, i_wait_n, slow = 0;
  logic o_data_lo_oe, o_data_hi_oe, o_rd_n, o_wr_lo_n, o_wr_hi_n;
  logic o_area_sel_0_n, o_area_sel_1_n, o_area_sel_2_n, o_area_sel_3_n;
  logic [3:0] sel_and = 4'hf;
  int num_errors = 0, cmp_count = 0, lat = 0;
  exp_t cq[$], aq[$], e;
  chip_select_area_decoder u_dut (.i_clock, .i_srst, .i_psel, .i_penable,
    .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr,
    .i_cycle_start, .i_cycle_write, .i_cycle_addr, .i_cycle_size,
    .i_cycle_wdata, .o_cycle_done, .o_cycle_busy, .o_cycle_rdata,
    .i_bus_width_strap, .i_wait_n, .i_data_lo, .i_data_hi, .o_data_lo,
    .o_data_hi, .o_data_lo_oe, .o_data_hi_oe, .o_addr, .o_rd_n, .o_wr_lo_n,
    .o_wr_hi_n, .o_area_sel_0_n, .o_area_sel_1_n, .o_area_sel_2_n,
    .o_area_sel_3_n);
  ext_mem u_mem (.i_clock, .i_slow(slow), .i_addr(o_addr), .i_rd_n(o_rd_n),
    .i_wr_lo_n(o_wr_lo_n), .i_wr_hi_n(o_wr_hi_n), .i_lo(o_data_lo),
    .i_hi(o_data_hi), .i_lo_oe(o_data_lo_oe), .i_hi_oe(o_data_hi_oe),
    .o_lo(i_data_lo), .o_hi(i_data_hi), .o_wait_n(i_wait_n));
  // ==========================================================
  // Clock, watchdog, checking tasks
  // ==========================================================
  initial
    forever #2 i_clock = ~i_clock;
  initial
  begin
    #40000;
    num_errors++;
    results();
  end
  task automatic chk(string s, logic [31:0] x, logic [31:0] g);
    cmp_count++;
    if (g !== x)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", s, x, g);
    end
  endtask
  task automatic results();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  function automatic logic [11:0] ra(logic [7:0] i);
    return {2'b00, i, 2'b00};
  endfunction
  // APB transfer: setup, then access held until pready
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d,
                     logic [31:0] x, logic [31:0] m, int err);
    aq.push_back('{x, m, err, 4'h0});
    @(posedge i_clock);
    i_psel <= 1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clock);
    i_penable <= 1;
    do @(posedge i_clock); while (o_pready !== 1);
    i_psel <= 0;
    i_penable <= 0;
  endtask
  task automatic wr(logic [7:0] i, logic [7:0] v);
    apb(1, ra(i), {24'h0, v}, 0, 0, 0);
  endtask
  // Operand transfer; expected bytes from the shadow or the fill pattern
  task automatic cyc(logic w, logic [23:0] a, int n, int l, logic [3:0] s);
    logic [31:0] d, m;
    logic [23:0] b;
    d = $urandom;
    m = 0;
    for (int k = 0; k < n; k++)
    begin
      b = a + 24'(k);
      m[8*k +: 8] = 8'hff;
      if (w)
        sh[b] = d[8*k +: 8];
      else
        d[8*k +: 8] = sh.exists(b) ? sh[b] : b[7:0] ^ b[15:8] ^ 8'h3c;
    end
    // Writes compare no bytes; reads compare only the bytes moved
    cq.push_back('{w ? 32'h0 : d & m, w ? 32'h0 : m, l, s});
    @(posedge i_clock);
    i_cycle_start <= 1;
    i_cycle_write <= w;
    i_cycle_addr <= a;
    i_cycle_size <= 3'(n);
    i_cycle_wdata <= d;
    @(posedge i_clock);
    i_cycle_start <= 0;
    do @(posedge i_clock); while (o_cycle_done !== 1);
  endtask
  // Watcher: latency, selects seen and data, against oldest note
  always @(posedge i_clock)
  begin
    lat++;
    sel_and &= {o_area_sel_3_n, o_area_sel_2_n, o_area_sel_1_n,
                o_area_sel_0_n};
    if (o_cycle_done === 1)
    begin
      e = cq.pop_front();
      chk("rdata", e.d, o_cycle_rdata & e.m);
      chk("selects", {28'h0, e.sel}, {28'h0, sel_and});
      if (e.lat >= 0)
        chk("latency", e.lat, lat);
    end
    if (i_cycle_start && !o_cycle_busy)
    begin
      lat = 0;
      sel_and = 4'hf;
    end
    if (i_psel && i_penable && o_pready === 1)
    begin
      e = aq.pop_front();
      chk("prdata", e.d, o_prdata & e.m);
      chk("pslverr", e.lat, {31'h0, o_pslverr});
    end
  end
  // ==========================================================
  // Scenarios; latency is 1 + beats * (2 + wait states), counted from
  // the edge that takes the start to the edge that sees done
  // ==========================================================
  initial
  begin
    logic [23:0] a;
    void'($urandom(25151));
    repeat (3) @(posedge i_clock);
    i_srst <= 0;
    @(posedge i_clock);
    for (int k = 0; k < 8; k++)
      apb(0, ra(8'(k < 4 ? 8'h3c + k : 8'h58 + k)), 0, 32'hff, '1, 0);
    apb(0, ra(csad_pkg::IDX_AREA2_CTRL), 0, 32'h10, '1, 0);
    apb(0, 12'h0f1, 0, 0, '1, 1);
    a = $urandom;
    wr(csad_pkg::IDX_AREA3_BASE, a[7:0]);
    apb(0, ra(csad_pkg::IDX_AREA3_BASE), 0, {24'h0, a[7:0]}, '1, 0);
    cyc(0, 24'h000080, 1, 5, 4'b1011);
    cyc(0, 24'h00007f, 1, 5, 4'b1111);
    wr(csad_pkg::IDX_AREA0_BASE, 8'h01);
    wr(csad_pkg::IDX_AREA0_MASK, 8'h07);
    wr(csad_pkg::IDX_AREA0_CTRL, 8'h13);
    a = {9'h002, 15'($urandom)} | 24'h1;
    cyc(1, a, 4, 7, 4'b1110);
    cyc(0, a, 4, 7, 4'b1110);
    cyc(0, 24'h210000, 1, 5, 4'b1011);
    wr(csad_pkg::IDX_AREA0_MASK, 8'h06);
    cyc(0, 24'h010100, 1, 5, 4'b1011);
    cyc(0, 24'h010200, 1, 3, 4'b1110);
    wr(csad_pkg::IDX_AREA1_BASE, 8'h01);
    wr(csad_pkg::IDX_AREA1_MASK, 8'hff);
    wr(csad_pkg::IDX_AREA1_CTRL, 8'h14);
    cyc(0, 24'h010000, 1, 3, 4'b1110);
    // Full mask hides the start bits: area 1 begins at zero, not 010000H
    cyc(0, 24'h000100, 1, 5, 4'b1101);
    cyc(0, 24'h3f0002, 2, 9, 4'b1101);
    for (int w = 0; w < 4; w++)
    begin
      wr(csad_pkg::IDX_AREA1_CTRL, 8'(8'h10 + w));
      cyc(0, 24'h3f0000, 1, w == 0 ? 5 : w == 3 ? 3 : 4, 4'b1101);
    end
    wr(csad_pkg::IDX_AREA1_CTRL, 8'h12);
    slow <= 1;
    cyc(0, 24'h3f0004, 2, -1, 4'b1101);
    slow <= 0;
    wr(csad_pkg::IDX_AREA0_CTRL, 8'h03);
    cyc(0, 24'h010200, 1, 4, 4'b1101);
    wr(csad_pkg::IDX_AREA2_BASE, 8'h40);
    wr(csad_pkg::IDX_AREA2_MASK, 8'h00);
    wr(csad_pkg::IDX_AREA2_CTRL, 8'h18);
    wr(csad_pkg::IDX_DEFAULT_CTRL, 8'h07);
    cyc(0, 24'h400000, 1, 5, 4'b1011);
    cyc(0, 24'h408000, 1, 3, 4'b1111);
    cyc(0, 24'h800000, 2, 5, 4'b1111);
    wr(csad_pkg::IDX_AREA3_BASE, 8'h80);
    wr(csad_pkg::IDX_AREA3_CTRL, 8'h1b);
    cyc(0, 24'h800000, 1, 4, 4'b0111);
    // Status shows the area of the last beat, here area 3, and not busy
    apb(0, ra(csad_pkg::IDX_STATUS), 0, 32'h03, '1, 0);
    wr(csad_pkg::IDX_AREA0_CTRL, 8'h13);
    i_bus_width_strap <= 1;
    cyc(1, 24'h010203, 2, 5, 4'b1110);
    cyc(0, 24'h010203, 2, 5, 4'b1110);
    results();
  end
endmodule
